//--- idsw_map.vh
`ifndef IDSW_MAP_VH
`define IDSW_MAP_VH
// ---------------------------------------------------------------
// register byte addresses (printed offsets are not all multiples of four)
// ---------------------------------------------------------------
`define IDSW_IDX_IO_BASE 16'h7F71
`define IDSW_IDX_MEM_BASE 16'h7F72
`define IDSW_IDX_STATUS 16'h7F73
`define IDSW_IDX_MASK 16'h7F74
`define IDSW_IDX_IRQ 16'h7F75
`define IDSW_ADDR_IO_BASE 18'h1FDC4
`define IDSW_ADDR_MEM_BASE 18'h1FDC8
`define IDSW_ADDR_STATUS 18'h1FDCC
`define IDSW_ADDR_MASK 18'h1FDD0
`define IDSW_ADDR_IRQ 18'h1FDD4
// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define IDSW_RST_MASK 8'hFF
`define IDSW_RST_BASE 8'h00
`define IDSW_TC_LSB 0
`define IDSW_TC_MSB 3
`define IDSW_DMA_SEL_BIT 15
`define IDSW_PKT_MSB 14
`define IDSW_PKT_LSB 10
`define IDSW_OFS_MSB 9
`define IDSW_PAGE_MSB 9
`define IDSW_PAGE_LSB 7
`define IDSW_EXT_MSB 14
`define IDSW_PAGE_BYTES 128
`define IDSW_MAX_PAGES 10
`define IDSW_HDR_BYTES 8
`define IDSW_RESP_OKAY 2'h0
`define IDSW_RESP_SLVERR 2'h2
`endif

//--- idsw_window_map.v
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`include "idsw_map.vh"
// What this block does
// - status mirror shows live controller channel status, no own latching
// - controller clears terminal-count bits 3..0 when status read through io window
// - reading the mirror register changes nothing
// - completion flag sets on rising edge of any unmasked mirrored bit
// - mask bits 7..4 gate requests, 3..0 terminal counts; 0 enables
// - mask resets to all ones
// - io cycle drives io base on address 15..8, offset below
// - memory cycle drives memory base on 19..12, 12-bit offset below
// - dma addresses below 0x8000 go to 32K external ram window
// - upper half selects one of 32 packet windows, bits 14..10 packet number
// - buffer manager maps packet offset bits 9..7 onto the first eight of ten 128-byte page pointers
// - all channels share one decoder; it decodes whichever channel's address is presented
// - packet offsets count from packet start including the 8-byte header
// - mirror bits 7..4 request pending ch3..0, bits 3..0 terminal count
module idsw_window_map #(
  parameter PAGE_BYTES = `IDSW_PAGE_BYTES,
  parameter MAX_PAGES = `IDSW_MAX_PAGES
) (
  input wire ref_clk,
  input wire rstn,
  input wire [17:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [17:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] dmaChannelStatusSource,
  input wire ioCycle,
  input wire [7:0] ioOffset,
  input wire memCycle,
  input wire [11:0] memOffset,
  input wire [15:0] dmaMemAddr,
  input wire [4:0] pagePtr0,
  input wire [4:0] pagePtr1,
  input wire [4:0] pagePtr2,
  input wire [4:0] pagePtr3,
  input wire [4:0] pagePtr4,
  input wire [4:0] pagePtr5,
  input wire [4:0] pagePtr6,
  input wire [4:0] pagePtr7,
  input wire [4:0] pagePtr8,
  input wire [4:0] pagePtr9,
  output reg [19:0] isaAddr,
  output reg isaAddrValid,
  output reg dmaExtSel,
  output reg [14:0] dmaExtAddr,
  output reg dmaPktSel,
  output reg [4:0] packetNumberTag,
  output reg [9:0] packetOffset,
  output reg [11:0] bufferAddr,
  output reg pageOverrun,
  output reg dmaCompletionIrqFlag,
  output reg [7:0] statusMirror
);
  // ---------------------------------------------------------------
  // page pointers, one per 128-byte page of the packet
  // ---------------------------------------------------------------
  wire [5*MAX_PAGES-1:0] pageTable;
  assign pageTable = {pagePtr9, pagePtr8, pagePtr7, pagePtr6, pagePtr5,
                      pagePtr4, pagePtr3, pagePtr2, pagePtr1, pagePtr0};

  // ---------------------------------------------------------------
  // status synchronisers and edge detection
  // ---------------------------------------------------------------
  reg [7:0] statSync1_q;
  reg [7:0] statSync2_q;
  reg [7:0] statPrev_q;
  reg [7:0] io_window_base_q;
  reg [7:0] isa_memory_window_base_q;
  reg [7:0] irqMask_q;
  wire [7:0] riseUnmasked;
  // status crosses from the controller's clock, so it is synchronised;
  // adds two cycles of latency to the mirror but never reads a metastable bit
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      statSync1_q <= 8'h00;
      statSync2_q <= 8'h00;
      statPrev_q <= 8'h00;
      statusMirror <= 8'h00;
    end else begin
      statSync1_q <= dmaChannelStatusSource;
      statSync2_q <= statSync1_q;
      statPrev_q <= statSync2_q;
      statusMirror <= statSync2_q;
    end
  end

  // ---------------------------------------------------------------
  // per-bit rise detection
  // ---------------------------------------------------------------
  // a set mask bit hides its source, but the mirror still shows it
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_rise
      assign riseUnmasked[b] = statSync2_q[b] & ~statPrev_q[b] & ~irqMask_q[b];
    end
  endgenerate

  // ---------------------------------------------------------------
  // register decode shared by the write and read paths
  // ---------------------------------------------------------------
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_IO_BASE = 3'h1;
  localparam [2:0] SEL_MEM_BASE = 3'h2;
  localparam [2:0] SEL_STATUS = 3'h3;
  localparam [2:0] SEL_MASK = 3'h4;
  localparam [2:0] SEL_IRQ = 3'h5;
  // unmapped addresses fall through to an error response
  function [2:0] regSelect;
    input [17:0] addr;
    begin
      if (addr == `IDSW_ADDR_IO_BASE) begin
        regSelect = SEL_IO_BASE;
      end else if (addr == `IDSW_ADDR_MEM_BASE) begin
        regSelect = SEL_MEM_BASE;
      end else if (addr == `IDSW_ADDR_STATUS) begin
        regSelect = SEL_STATUS;
      end else if (addr == `IDSW_ADDR_MASK) begin
        regSelect = SEL_MASK;
      end else if (addr == `IDSW_ADDR_IRQ) begin
        regSelect = SEL_IRQ;
      end else begin
        regSelect = SEL_NONE;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  reg [17:0] awAddr_q;
  reg awHave_q;
  reg [7:0] wByte_q;
  reg wStrb0_q;
  reg wHave_q;
  wire doWrite;
  reg wrHit;
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  wire [2:0] wrSel;
  wire wrIoBase;
  wire wrMemBase;
  wire wrMask;
  assign wrSel = regSelect(awAddr_q);
  // a status write is accepted and ignored, so it still answers okay
  always @* begin
    wrHit = (wrSel != SEL_NONE);
  end
  // only byte lane 0 carries register data; upper lanes are dropped
  assign wrIoBase = doWrite && wStrb0_q && (wrSel == SEL_IO_BASE);
  assign wrMemBase = doWrite && wStrb0_q && (wrSel == SEL_MEM_BASE);
  assign wrMask = doWrite && wStrb0_q && (wrSel == SEL_MASK);
  wire irqClear;
  assign irqClear = doWrite && wStrb0_q && (wrSel == SEL_IRQ) && wByte_q[0];

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awAddr_q <= 18'h00000;
      awHave_q <= 1'b0;
      wByte_q <= 8'h00;
      wStrb0_q <= 1'b0;
      wHave_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IDSW_RESP_OKAY;
      io_window_base_q <= `IDSW_RST_BASE;
      isa_memory_window_base_q <= `IDSW_RST_BASE;
      irqMask_q <= `IDSW_RST_MASK;
    end else begin
      s_axi_awready <= !awHave_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHave_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        awHave_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wByte_q <= s_axi_wdata[7:0];
        wStrb0_q <= s_axi_wstrb[0];
        wHave_q <= 1'b1;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `IDSW_RESP_OKAY : `IDSW_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wrIoBase) begin
        io_window_base_q <= wByte_q;
      end
      if (wrMemBase) begin
        isa_memory_window_base_q <= wByte_q;
      end
      if (wrMask) begin
        irqMask_q <= wByte_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // completion flag
  // ---------------------------------------------------------------
  // sticky so a short status pulse is not lost before firmware looks
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dmaCompletionIrqFlag <= 1'b0;
    end else begin
      // a new edge in the clearing cycle wins over the clear
      if (|riseUnmasked) begin
        dmaCompletionIrqFlag <= 1'b1;
      end else if (irqClear) begin
        dmaCompletionIrqFlag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read path; reads have no side effects
  // ---------------------------------------------------------------
  reg [7:0] rdByte;
  reg rdHit;
  wire [2:0] rdSel;
  assign rdSel = regSelect(s_axi_araddr);
  always @* begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    if (rdSel == SEL_IO_BASE) begin
      rdByte = io_window_base_q;
    end else if (rdSel == SEL_MEM_BASE) begin
      rdByte = isa_memory_window_base_q;
    end else if (rdSel == SEL_STATUS) begin
      rdByte = statSync2_q;
    end else if (rdSel == SEL_MASK) begin
      rdByte = irqMask_q;
    end else if (rdSel == SEL_IRQ) begin
      rdByte = {7'h00, dmaCompletionIrqFlag};
    end else begin
      rdHit = 1'b0;
    end
  end
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `IDSW_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdHit ? `IDSW_RESP_OKAY : `IDSW_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // isa address forming for microcontroller window cycles
  // ---------------------------------------------------------------
  // the status-clear side effect of reading the controller's own status
  // register lives inside the controller; this block only forms the address
  reg [19:0] isaAddr_d;
  // the address holds between cycles so idle lines do not toggle
  always @* begin
    isaAddr_d = isaAddr;
    if (ioCycle) begin
      isaAddr_d = {4'h0, io_window_base_q, ioOffset};
    end else if (memCycle) begin
      isaAddr_d = {isa_memory_window_base_q, memOffset};
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      isaAddr <= 20'h00000;
      isaAddrValid <= 1'b0;
    end else begin
      isaAddrValid <= ioCycle | memCycle;
      isaAddr <= isaAddr_d;
    end
  end

  // ---------------------------------------------------------------
  // dma memory address decode and page remap
  // ---------------------------------------------------------------
  // one decoder shared by all channels; the address presented is
  // whichever channel currently owns the bus
  function [4:0] pageSelect;
    input [5*MAX_PAGES-1:0] tbl;
    input [9:0] ofs;
    integer i;
    begin
      pageSelect = 5'h00;
      // a 1K window spans eight 128-byte pages, so the last pointers
      // of a ten-page packet are never reached through this window
      for (i = 0; i < MAX_PAGES; i = i + 1) begin
        if (ofs[`IDSW_PAGE_MSB:`IDSW_PAGE_LSB] == i) begin
          pageSelect = tbl[5*i +: 5];
        end
      end
    end
  endfunction
  wire [9:0] dmaOfs;
  wire [3:0] pageIdx;
  assign dmaOfs = dmaMemAddr[`IDSW_OFS_MSB:0];
  // with ten or more pages per packet the overrun flag stays low
  assign pageIdx = {1'b0, dmaOfs[`IDSW_PAGE_MSB:`IDSW_PAGE_LSB]};
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dmaExtSel <= 1'b0;
      dmaExtAddr <= 15'h0000;
      dmaPktSel <= 1'b0;
      packetNumberTag <= 5'h00;
      packetOffset <= 10'h000;
      bufferAddr <= 12'h000;
      pageOverrun <= 1'b0;
    end else begin
      dmaExtSel <= ~dmaMemAddr[`IDSW_DMA_SEL_BIT];
      dmaExtAddr <= dmaMemAddr[`IDSW_EXT_MSB:0];
      dmaPktSel <= dmaMemAddr[`IDSW_DMA_SEL_BIT];
      packetNumberTag <= dmaMemAddr[`IDSW_PKT_MSB:`IDSW_PKT_LSB];
      packetOffset <= dmaOfs;
      bufferAddr <= {pageSelect(pageTable, dmaOfs), dmaOfs[6:0]};
      pageOverrun <= dmaMemAddr[`IDSW_DMA_SEL_BIT] && (pageIdx >= MAX_PAGES);
    end
  end
endmodule

//--- idsw_window_map_props.sv
`timescale 1ns/1ns
// ----------
// window map checks
// ----------
module idsw_window_map_props #(parameter PAGE_BYTES = 128, parameter MAX_PAGES = 10) (
  input wire ref_clk,
  input wire rstn,
  input wire s_axi_wvalid,
  input wire [7:0] dmaChannelStatusSource,
  input wire ioCycle,
  input wire [7:0] ioOffset,
  input wire memCycle,
  input wire [11:0] memOffset,
  input wire [15:0] dmaMemAddr,
  input wire [4:0] pagePtr3,
  input wire [19:0] isaAddr,
  input wire isaAddrValid,
  input wire dmaExtSel,
  input wire [14:0] dmaExtAddr,
  input wire dmaPktSel,
  input wire [4:0] packetNumberTag,
  input wire [9:0] packetOffset,
  input wire [11:0] bufferAddr,
  input wire dmaCompletionIrqFlag,
  input wire [7:0] statusMirror
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // two sync flops plus the output register give three cycles
  mirror_live_a: assert property (statusMirror == $past(dmaChannelStatusSource, 3))
    else $error("mirror lags status");
  flag_set_a: assert property ($rose(dmaCompletionIrqFlag) |->
    |(statusMirror & ~$past(statusMirror))) else $error("flag without rise");
  flag_keep_a: assert property ($fell(dmaCompletionIrqFlag) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)) else $error("flag dropped alone");
  io_addr_a: assert property (ioCycle |=> isaAddrValid && isaAddr[7:0] == $past(ioOffset))
    else $error("io address wrong");
  mem_addr_a: assert property (memCycle |=> isaAddr[11:0] == $past(memOffset))
    else $error("mem address wrong");
  ext_win_a: assert property (!dmaMemAddr[15] |=> dmaExtSel && !dmaPktSel
    && dmaExtAddr == $past(dmaMemAddr[14:0])) else $error("ext window wrong");
  pkt_win_a: assert property (dmaMemAddr[15] |=> dmaPktSel && !dmaExtSel
    && {packetNumberTag, packetOffset} == $past(dmaMemAddr[14:0])) else $error("packet window");
  page_map_a: assert property (dmaMemAddr[15] && dmaMemAddr[9:7] == 3'h3 |=>
    bufferAddr == {$past(pagePtr3), $past(dmaMemAddr[6:0])}) else $error("page map wrong");
endmodule
bind idsw_window_map idsw_window_map_props #(.PAGE_BYTES(PAGE_BYTES), .MAX_PAGES(MAX_PAGES))
  u_props (.*);

//--- idsw_dma_model.sv
`timescale 1ns/1ns
// ----------
// dma controller status model
// ----------
module idsw_dma_model (
  input wire ref_clk,
  input wire ioCycle,
  input wire [7:0] ioOffset,
  output reg [7:0] stat_q
);
  initial stat_q = 8'h00;
  task put(input [7:0] v);
    @(posedge ref_clk);
    stat_q <= v;
  endtask
  // a status read through the io window drops the terminal counts
  always @(posedge ref_clk)
    if (ioCycle && ioOffset == 8'h08) stat_q <= stat_q & 8'hF0;
endmodule

//--- idsw_window_map_bench.sv
`timescale 1ns/1ns
`include "idsw_map.vh"
// ----------
// window map bench
// ----------
module idsw_window_map_bench;
  localparam [127:0] ADDRS = {16'h0000, 16'h7FFF, 16'h8000, 16'h83FF, 16'hA827, 16'h81A5,
    16'hFC00, 16'hFFFF};
  reg ref_clk = 1'b0, rstn = 1'b0;
  reg [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ioCycle = 1'b0, memCycle = 1'b0;
  reg [7:0] ioOffset = 8'h00;
  reg [11:0] memOffset = 12'h000;
  reg [15:0] dmaMemAddr = 16'h0000, a;
  reg [4:0] ptr [0:9];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] dmaChannelStatusSource, statusMirror;
  wire [19:0] isaAddr;
  wire [14:0] dmaExtAddr;
  wire [4:0] packetNumberTag;
  wire [9:0] packetOffset;
  wire [11:0] bufferAddr;
  wire dmaExtSel, dmaPktSel, dmaCompletionIrqFlag, isaAddrValid, pageOverrun;
  integer errors = 0, cmp_count = 0, i;
  always #4 ref_clk = ~ref_clk;
  idsw_dma_model model (.ref_clk(ref_clk), .ioCycle(ioCycle), .ioOffset(ioOffset),
    .stat_q(dmaChannelStatusSource));
  idsw_window_map dut (.*,
    .pagePtr0(ptr[0]), .pagePtr1(ptr[1]), .pagePtr2(ptr[2]), .pagePtr3(ptr[3]),
    .pagePtr4(ptr[4]), .pagePtr5(ptr[5]), .pagePtr6(ptr[6]), .pagePtr7(ptr[7]),
    .pagePtr8(ptr[8]), .pagePtr9(ptr[9]));
  task chk(input [31:0] seen, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // each channel is released on its own handshake; only the watchdog ends a wait
  task wr(input [17:0] ad, input [31:0] d, input [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task rd(input [17:0] ad, input [31:0] d, input [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task cyc(input io, input [11:0] ofs);
    @(posedge ref_clk);
    ioCycle <= io;
    memCycle <= !io;
    ioOffset <= ofs[7:0];
    memOffset <= ofs;
    @(posedge ref_clk);
    ioCycle <= 1'b0;
    memCycle <= 1'b0;
    #1;
  endtask
  initial begin
    #40000;
    errors = errors + 1;
    wrap_up;
  end
  initial begin
    for (i = 0; i < 10; i = i + 1) ptr[i] = 5'h1F - i[4:0];
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`IDSW_ADDR_MASK, 32'hFF, `IDSW_RESP_OKAY);
    rd(`IDSW_ADDR_IO_BASE, 32'h0, `IDSW_RESP_OKAY);
    rd(18'h00100, 32'h0, `IDSW_RESP_SLVERR);
    $display("test reset done");
    wr(`IDSW_ADDR_IO_BASE, 32'h5A, `IDSW_RESP_OKAY);
    cyc(1'b1, 12'h03C);
    chk({12'h0, isaAddr}, 32'h05A3C);
    chk({31'h0, isaAddrValid}, 32'h1);
    s_axi_wstrb <= 4'h0;
    wr(`IDSW_ADDR_IO_BASE, 32'hA5, `IDSW_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`IDSW_ADDR_IO_BASE, 32'h5A, `IDSW_RESP_OKAY);
    wr(`IDSW_ADDR_MEM_BASE, 32'hC3, `IDSW_RESP_OKAY);
    cyc(1'b0, 12'h9A5);
    chk({12'h0, isaAddr}, 32'hC39A5);
    @(posedge ref_clk);
    #1;
    chk({31'h0, isaAddrValid}, 32'h0);
    $display("test windows done");
    for (i = 0; i < 8; i = i + 1) begin
      a = ADDRS[16*i +: 16];
      @(posedge ref_clk);
      dmaMemAddr <= a;
      @(posedge ref_clk);
      #1;
      chk({15'h0, dmaPktSel, dmaExtSel, a[15] ? {packetNumberTag, packetOffset} : dmaExtAddr},
        {15'h0, a[15], ~a[15], a[14:0]});
      if (a[15]) chk({20'h0, bufferAddr}, {20'h0, 5'h1F - {2'h0, a[9:7]}, a[6:0]});
      chk({31'h0, pageOverrun}, 32'h0);
    end
    $display("test decode done");
    model.put(8'h01);
    repeat (6) @(posedge ref_clk);
    chk({31'h0, dmaCompletionIrqFlag}, 32'h0);
    rd(`IDSW_ADDR_STATUS, 32'h01, `IDSW_RESP_OKAY);
    wr(`IDSW_ADDR_MASK, 32'hFE, `IDSW_RESP_OKAY);
    model.put(8'h00);
    repeat (6) @(posedge ref_clk);
    model.put(8'h01);
    repeat (6) @(posedge ref_clk);
    model.put(8'h00);
    repeat (6) @(posedge ref_clk);
    rd(`IDSW_ADDR_IRQ, 32'h1, `IDSW_RESP_OKAY);
    wr(`IDSW_ADDR_IRQ, 32'h1, `IDSW_RESP_OKAY);
    rd(`IDSW_ADDR_IRQ, 32'h0, `IDSW_RESP_OKAY);
    wr(`IDSW_ADDR_MASK, 32'hEF, `IDSW_RESP_OKAY);
    model.put(8'h13);
    repeat (6) @(posedge ref_clk);
    rd(`IDSW_ADDR_IRQ, 32'h1, `IDSW_RESP_OKAY);
    rd(`IDSW_ADDR_STATUS, 32'h13, `IDSW_RESP_OKAY);
    rd(`IDSW_ADDR_STATUS, 32'h13, `IDSW_RESP_OKAY);
    cyc(1'b1, 12'h008);
    repeat (6) @(posedge ref_clk);
    rd(`IDSW_ADDR_STATUS, 32'h10, `IDSW_RESP_OKAY);
    $display("test status done");
    wrap_up;
  end
endmodule
